// *** design/dacm_ctrl.sv ***
// attenuation, soft mute and output disable control registers
// Function
// - top word bit: zero writes, one reads
// - bits fourteen to eight pick the register
// - six independent 8-bit attenuation settings
// - level in dB is half of setting minus 255
// - settings of 128 or below mean mute
// - attenuation settings reset to 255, 0 dB
// - one load-enable bit governs all attenuators
// - load enable low disables and discards settings
// - level ramps one half-dB step per interval
// - rate bit picks two or four samples
// - six soft-mute bits, reset cleared, normal operation
// - soft mute ramps channel down to mute while load enable is set
// - unmute ramps back to programmed level
// - six output-disable bits, cleared connects converter
// - disable bit switches amplifier to mid-supply
`timescale 1ns/1ps
`default_nettype none
module dacm_ctrl
  import dacm_pkg::*;
#(
  parameter int CHANNELS = NUM_CHAN
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // control words from the serial port framing
  input wire logic i_word_valid,
  input wire logic [WORD_W-1:0] i_word,
  // one pulse per audio sample period
  input wire logic i_fs_tick,
  // read answer
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  // attenuator outputs
  output logic [CHANNELS-1:0][DATA_W-1:0] o_channel_atten_level,
  output logic [CHANNELS-1:0] o_channel_muted,
  // analog side controls
  output logic [CHANNELS-1:0] o_channel_output_disable,
  output logic o_zero_detect_mute_en,
  output logic [REG9_FIELD_W-1:0] o_filter_clock_format
);
  dacm_word_t word;
  logic wr_stb;
  logic rd_stb;
  logic [CHANNELS-1:0][DATA_W-1:0] channel_atten_level;
  logic atten_load_enable;
  dacm_rate_t atten_ramp_rate_sel;
  logic [CHANNELS-1:0] soft_mute_channel;
  logic [CHANNELS-1:0] channel_output_disable;
  logic zero_detect_mute_en;
  logic [REG9_FIELD_W-1:0] filter_clock_format;
  logic [STEP_CNT_W-1:0] fs_count;
  logic [STEP_CNT_W-1:0] step_last;
  logic step_tick;
  logic [DATA_W-1:0] next_rd_data;

  // decode helpers
  function automatic logic is_atten_idx(input logic [IDX_W-1:0] idx);
    return idx >= IDX_CH1_ATTEN && idx <= IDX_CH6_ATTEN;
  endfunction

  function automatic logic [DATA_W-1:0] mute_floor(
    input logic [DATA_W-1:0] lvl);
    return (lvl <= MUTE_LEVEL) ? MUTE_LEVEL : lvl;
  endfunction

  assign word = dacm_word_t'(i_word);
  assign wr_stb = i_word_valid && word.rw == RW_WRITE;
  assign rd_stb = i_word_valid && word.rw == RW_READ;

  // attenuation settings, one per channel
  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
      localparam logic [IDX_W-1:0] MY_IDX =
        IDX_CH1_ATTEN + IDX_W'(c);
      logic [DATA_W-1:0] target;

      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          channel_atten_level[c] <= ATTEN_RESET;
        end else if (!atten_load_enable) begin
          channel_atten_level[c] <= ATTEN_RESET;
        end else if (wr_stb && word.register_index == MY_IDX) begin
          channel_atten_level[c] <= word.data;
        end
      end

      // mute pulls target to the floor, unmute restores it
      assign target = soft_mute_channel[c] ? MUTE_LEVEL :
        mute_floor(channel_atten_level[c]);

      dacm_ramp u_ramp (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_enable(atten_load_enable),
        .i_step(step_tick),
        .i_target(target),
        .o_level(o_channel_atten_level[c])
      );

      // level equals 0.5 * (value - 255) dB; floor is mute
      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          o_channel_muted[c] <= 1'b0;
        end else begin
          o_channel_muted[c] <= atten_load_enable &&
            o_channel_atten_level[c] <= MUTE_LEVEL;
        end
      end
    end
  endgenerate

  // load, rate and soft mute register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      atten_load_enable <= CTRL_RESET[LOAD_EN_BIT];
      atten_ramp_rate_sel <= DACM_RATE_FAST;
      soft_mute_channel <= CTRL_RESET[CHANNELS-1:0];
    end else if (wr_stb && word.register_index == IDX_LOAD_RATE_MUTE) begin
      atten_load_enable <= word.data[LOAD_EN_BIT];
      atten_ramp_rate_sel <= dacm_rate_t'(word.data[RATE_SEL_BIT]);
      soft_mute_channel <= word.data[CHANNELS-1:0];
    end
  end

  // zero-detect enable and output disable register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      zero_detect_mute_en <= CTRL_RESET[ZERO_MUTE_BIT];
      channel_output_disable <= CTRL_RESET[CHANNELS-1:0];
    end else if (wr_stb && word.register_index == IDX_ZMUTE_OUT_DIS) begin
      zero_detect_mute_en <= word.data[ZERO_MUTE_BIT];
      channel_output_disable <= word.data[CHANNELS-1:0];
    end
  end

  // filter, clock and format fields held for the logic that uses them
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      filter_clock_format <= CTRL_RESET[REG9_FIELD_W-1:0];
    end else if (wr_stb && word.register_index == IDX_FILT_CLK_FMT) begin
      filter_clock_format <= word.data[REG9_FIELD_W-1:0];
    end
  end

  // ramp step interval counted in sample periods
  assign step_last = (atten_ramp_rate_sel == DACM_RATE_SLOW) ?
    STEP_SLOW_LAST : STEP_FAST_LAST;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fs_count <= '0;
      step_tick <= 1'b0;
    end else begin
      step_tick <= 1'b0;
      if (i_fs_tick) begin
        if (fs_count >= step_last) begin
          fs_count <= '0;
          step_tick <= 1'b1;
        end else begin
          fs_count <= fs_count + STEP_CNT_W'(1);
        end
      end
    end
  end

  // read-back mux; unmapped indices answer zero
  always_comb begin
    next_rd_data = READ_NONE;
    if (is_atten_idx(word.register_index)) begin
      next_rd_data = channel_atten_level[
        word.register_index - IDX_CH1_ATTEN];
    end else begin
      case (word.register_index)
        IDX_LOAD_RATE_MUTE: begin
          next_rd_data[LOAD_EN_BIT] = atten_load_enable;
          next_rd_data[RATE_SEL_BIT] = atten_ramp_rate_sel;
          next_rd_data[CHANNELS-1:0] = soft_mute_channel;
        end
        IDX_ZMUTE_OUT_DIS: begin
          next_rd_data[ZERO_MUTE_BIT] = zero_detect_mute_en;
          next_rd_data[CHANNELS-1:0] = channel_output_disable;
        end
        IDX_FILT_CLK_FMT: begin
          next_rd_data[REG9_FIELD_W-1:0] = filter_clock_format;
        end
        default: begin
          next_rd_data = READ_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= READ_NONE;
    end else begin
      o_rd_valid <= rd_stb;
      if (rd_stb) begin
        o_rd_data <= next_rd_data;
      end
    end
  end

  // outputs to the analog side from flops
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_channel_output_disable <= CTRL_RESET[CHANNELS-1:0];
      o_zero_detect_mute_en <= 1'b0;
      o_filter_clock_format <= CTRL_RESET[REG9_FIELD_W-1:0];
    end else begin
      o_channel_output_disable <= channel_output_disable;
      o_zero_detect_mute_en <= zero_detect_mute_en;
      o_filter_clock_format <= filter_clock_format;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_load_off_discard: assert property (
    !atten_load_enable |=> channel_atten_level[0] == ATTEN_RESET &&
      o_channel_atten_level[0] == ATTEN_RESET)
    else $error("attenuator data kept while load disabled");
  a_atten_write: assert property (
    wr_stb && atten_load_enable && word.register_index == IDX_CH1_ATTEN
      |=> channel_atten_level[0] == $past(word.data))
    else $error("channel one attenuation write lost");
  a_read_no_write: assert property (
    rd_stb && atten_load_enable |=> $stable(channel_atten_level[0]) &&
      $stable(soft_mute_channel))
    else $error("read word changed a register");
  a_read_ctrl: assert property (
    rd_stb && word.register_index == IDX_LOAD_RATE_MUTE |=>
      o_rd_valid && o_rd_data == {$past(atten_load_enable),
      $past(atten_ramp_rate_sel == DACM_RATE_SLOW),
      $past(soft_mute_channel)})
    else $error("control register read back wrong");
  a_mute_target: assert property (
    soft_mute_channel[0] |-> g_chan[0].target == MUTE_LEVEL)
    else $error("soft mute target is not the floor");
  a_floor_target: assert property (
    !soft_mute_channel[0] && channel_atten_level[0] <= MUTE_LEVEL |->
      g_chan[0].target == MUTE_LEVEL)
    else $error("low setting not treated as mute");
  a_fast_step: assert property (
    step_tick |=> !step_tick)
    else $error("step tick longer than one cycle");
  a_step_spacing: assert property (
    step_tick && atten_ramp_rate_sel == DACM_RATE_SLOW && !i_fs_tick &&
      $stable(atten_ramp_rate_sel) |=> fs_count == '0)
    else $error("step counter not restarted");
  a_out_disable: assert property (
    wr_stb && word.register_index == IDX_ZMUTE_OUT_DIS |=> ##1
      o_channel_output_disable == $past(word.data[CHANNELS-1:0], 2))
    else $error("output disable not applied");
  a_zero_en: assert property (
    wr_stb && word.register_index == IDX_ZMUTE_OUT_DIS |=> ##1
      o_zero_detect_mute_en == $past(word.data[ZERO_MUTE_BIT], 2))
    else $error("zero detect enable not applied");

  c_mute_reached: cover property (
    soft_mute_channel[0] && o_channel_muted[0]);
  c_slow_step: cover property (
    atten_ramp_rate_sel == DACM_RATE_SLOW && step_tick);
  c_unmute: cover property (
    $fell(soft_mute_channel[0]) ##[1:300] !o_channel_muted[0]);
  c_read: cover property (o_rd_valid);
endmodule
`default_nettype wire

// *** pkg/dacm_pkg.sv ***
// constants and types for the dac attenuation and mute control block
package dacm_pkg;
  localparam int NUM_CHAN = 6;
  localparam int IDX_W = 7;
  localparam int DATA_W = 8;
  // control word layout
  localparam int WORD_W = 16;
  localparam int RW_BIT = 15;
  localparam int IDX_MSB = 14;
  localparam int IDX_LSB = 8;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  // register indices
  localparam logic [IDX_W-1:0] IDX_CH1_ATTEN = 7'h01;
  localparam logic [IDX_W-1:0] IDX_CH6_ATTEN = 7'h06;
  localparam logic [IDX_W-1:0] IDX_LOAD_RATE_MUTE = 7'h07;
  localparam logic [IDX_W-1:0] IDX_ZMUTE_OUT_DIS = 7'h08;
  localparam logic [IDX_W-1:0] IDX_FILT_CLK_FMT = 7'h09;
  // field positions
  localparam int LOAD_EN_BIT = 7;
  localparam int RATE_SEL_BIT = 6;
  localparam int ZERO_MUTE_BIT = 6;
  localparam int REG9_FIELD_W = 6;
  // reset values and levels
  localparam logic [DATA_W-1:0] ATTEN_RESET = 8'hFF;
  localparam logic [DATA_W-1:0] MUTE_LEVEL = 8'h80;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_NONE = 8'h00;
  // ramp step interval in sample periods
  localparam int STEP_SLOW_FS = 4;
  localparam int STEP_FAST_FS = 2;
  localparam int STEP_CNT_W = 2;
  localparam logic [STEP_CNT_W-1:0] STEP_SLOW_LAST =
    STEP_CNT_W'(STEP_SLOW_FS - 1);
  localparam logic [STEP_CNT_W-1:0] STEP_FAST_LAST =
    STEP_CNT_W'(STEP_FAST_FS - 1);

  typedef struct packed {
    logic rw;
    logic [IDX_W-1:0] register_index;
    logic [DATA_W-1:0] data;
  } dacm_word_t;

  typedef enum logic {
    DACM_RATE_FAST,
    DACM_RATE_SLOW
  } dacm_rate_t;
endpackage

// *** design/dacm_ramp.sv ***
// one channel of stepwise attenuation ramping
`timescale 1ns/1ps
`default_nettype none
module dacm_ramp
  import dacm_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // control
  input wire logic i_enable,
  input wire logic i_step,
  input wire logic [DATA_W-1:0] i_target,
  // applied level
  output logic [DATA_W-1:0] o_level
);
  // disabled attenuator passes 0 dB; otherwise walk one step per tick
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_level <= ATTEN_RESET;
    end else if (!i_enable) begin
      o_level <= ATTEN_RESET;
    end else if (i_step) begin
      if (o_level < i_target) begin
        o_level <= o_level + 8'h01;
      end else if (o_level > i_target) begin
        o_level <= o_level - 8'h01;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_one_step_move: assert property (
    $past(i_enable) && i_enable && $changed(o_level) |->
      (o_level == $past(o_level) + 8'h01) ||
      (o_level == $past(o_level) - 8'h01))
    else $error("ramp moved more than one step");
  a_hold_no_tick: assert property (
    i_enable && !i_step |=> $stable(o_level) || !$past(i_enable) ||
      !i_enable)
    else $error("ramp moved without a step tick");
  a_toward_target: assert property (
    i_enable && i_step && o_level < i_target |=>
      !$past(i_enable) || o_level == $past(o_level) + 8'h01)
    else $error("ramp did not rise toward target");
endmodule
`default_nettype wire

// *** verif/dacm_host.sv ***
// host model issuing control words on the register port
`timescale 1ns/1ps
`default_nettype none
module dacm_host
  import dacm_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // read answer
  input wire logic i_rd_valid,
  input wire logic [DATA_W-1:0] i_rd_data,
  // control words
  output logic o_word_valid,
  output logic [WORD_W-1:0] o_word
);
  initial begin
    o_word_valid = 1'b0;
    o_word = 16'h0000;
  end

  task automatic xfer(input logic rw, input logic [IDX_W-1:0] idx,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    dacm_word_t w;
    int n;
    w = '{rw: rw, register_index: idx, data: d};
    @(posedge i_ref_clk);
    #1;
    o_word_valid = 1'b1;
    o_word = w;
    @(posedge i_ref_clk);
    #1;
    o_word_valid = 1'b0;
    // released word must not keep its old value
    o_word = ~w;
    q = 'x;
    for (n = 0; n < 4 && rw == RW_READ; n++) begin
      if (i_rd_valid === 1'b1) begin
        q = i_rd_data;
        break;
      end
      @(posedge i_ref_clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// *** verif/tb_dacm_ctrl.sv ***
// self-checking bench for the attenuation and mute control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_compared++; \
  if ((got) !== $bits(got)'(exp)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", what, exp, got); end end
module tb_dacm_ctrl
  import dacm_pkg::*;
;
  localparam int FS_DIV = 4;
  localparam int SETTLE = 128 * STEP_SLOW_FS * FS_DIV + 8;
  logic i_ref_clk, i_rst_b, i_word_valid, i_fs_tick, o_rd_valid, zen;
  logic [WORD_W-1:0] i_word;
  logic [DATA_W-1:0] o_rd_data;
  logic [NUM_CHAN-1:0][DATA_W-1:0] lvl;
  logic [NUM_CHAN-1:0] muted, dis;
  logic [REG9_FIELD_W-1:0] fmt;
  int bad_count = 0;
  int n_compared = 0;
  int set_m[NUM_CHAN];
  int ctl7, ctl8, reg9, i;

  dacm_ctrl #(.CHANNELS(NUM_CHAN)) u_dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_word_valid(i_word_valid), .i_word(i_word), .i_fs_tick(i_fs_tick),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_channel_atten_level(lvl), .o_channel_muted(muted),
    .o_channel_output_disable(dis), .o_zero_detect_mute_en(zen),
    .o_filter_clock_format(fmt));
  dacm_host u_host (
    .i_ref_clk(i_ref_clk), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .o_word_valid(i_word_valid), .o_word(i_word));

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  // one sample period every FS_DIV clocks
  initial begin
    i_fs_tick = 1'b0;
    forever begin
      repeat (FS_DIV - 1) @(posedge i_ref_clk);
      #1 i_fs_tick = 1'b1;
      @(posedge i_ref_clk);
      #1 i_fs_tick = 1'b0;
    end
  end

  function automatic int exp_rd(int idx);
    if (idx >= 1 && idx <= 6) return set_m[idx-1];
    if (idx == 7) return ctl7;
    if (idx == 8) return ctl8 & 8'h7F;
    if (idx == 9) return reg9 & 8'h3F;
    return 0;
  endfunction
  function automatic int exp_lvl(int c);
    if (!ctl7[7]) return 255;
    if (ctl7[c]) return 128;
    return set_m[c] > 128 ? set_m[c] : 128;
  endfunction

  task automatic model_reset();
    ctl7 = 0;
    ctl8 = 0;
    reg9 = 0;
    foreach (set_m[c]) set_m[c] = 255;
  endtask
  task automatic wr(int idx, int d);
    logic [DATA_W-1:0] q;
    u_host.xfer(RW_WRITE, IDX_W'(idx), DATA_W'(d), q);
    if (idx >= 1 && idx <= 6 && ctl7[7]) set_m[idx-1] = d;
    if (idx == 7) ctl7 = d;
    if (idx == 7 && !d[7]) foreach (set_m[c]) set_m[c] = 255;
    if (idx == 8) ctl8 = d;
    if (idx == 9) reg9 = d;
  endtask
  task automatic rd(int idx);
    logic [DATA_W-1:0] q;
    u_host.xfer(RW_READ, IDX_W'(idx), 8'h00, q);
    `CHK("read data", exp_rd(idx), q)
  endtask
  task automatic outs();
    #1;
    for (int c = 0; c < NUM_CHAN; c++) begin
      `CHK("level", exp_lvl(c), lvl[c])
      `CHK("muted", ctl7[7] && exp_lvl(c) <= 128, muted[c])
      `CHK("disable", ctl8[c], dis[c])
    end
    `CHK("zero mute en", ctl8[6], zen)
    `CHK("reg9 field", reg9 & 8'h3F, fmt)
  endtask
  // time between two successive ramp steps of one channel
  task automatic gap_chk(int c, int rate);
    logic [DATA_W-1:0] v;
    int n;
    wr(7, 8'h80 | (rate << 6));
    wr(c + 1, set_m[c] - 4);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      v = lvl[c];
      while (lvl[c] === v && n < 200) begin
        @(posedge i_ref_clk);
        #1;
        n++;
      end
    end
    `CHK("step gap", (rate ? STEP_SLOW_FS : STEP_FAST_FS) * FS_DIV, n)
    `CHK("step size", v - 1, lvl[c])
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge i_ref_clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    i_rst_b = 1'b0;
    void'($urandom(32'h3dd9));
    model_reset();
    repeat (10) @(posedge i_ref_clk);
    #1 i_rst_b = 1'b1;
    outs();
    for (i = 0; i < 12; i++) rd(i);
    wr(1, 8'h20);
    rd(1);
    wr(7, 8'h80);
    for (i = 0; i < NUM_CHAN; i++) begin
      wr(i + 1, i == 0 ? $urandom % 128 : i == 1 ? 128 : i == 3 ? 129 :
        8'h90 + $urandom % 8'h70);
      rd(i + 1);
    end
    repeat (SETTLE) @(posedge i_ref_clk);
    outs();
    gap_chk(2, 0);
    gap_chk(2, 1);
    wr(7, 8'hC1 | ($urandom % 64));
    repeat (SETTLE) @(posedge i_ref_clk);
    outs();
    wr(7, 8'hC0);
    repeat (SETTLE) @(posedge i_ref_clk);
    outs();
    wr(8, $urandom % 256);
    rd(8);
    wr(9, $urandom % 256);
    rd(9);
    wr(12, 8'h55);
    rd(12);
    repeat (3) @(posedge i_ref_clk);
    outs();
    wr(7, 8'h00);
    repeat (3) @(posedge i_ref_clk);
    outs();
    wr(7, 8'h80);
    rd(2);
    @(posedge i_ref_clk);
    #1 i_rst_b = 1'b0;
    model_reset();
    repeat (2) @(posedge i_ref_clk);
    #1 i_rst_b = 1'b1;
    outs();
    give_verdict();
  end
endmodule
`default_nettype wire
